// ===== rtl/xmbc_pkg.sv
// package for the external memory bus configuration block
// assumes a byte-wide i/o register port and a 100 MHz system clock
package xmbc_pkg;

  // ----------------------------------------------------------------
  // register offsets (i/o space)
  // ----------------------------------------------------------------
  localparam logic [7:0] MCU_GENERAL_CONTROL_OFS = 8'h35;
  localparam logic [7:0] EXT_MEM_CONTROL_B_OFS   = 8'h6C;
  localparam logic [7:0] EXT_MEM_CONTROL_A_OFS   = 8'h6D;
  localparam logic [7:0] REG_RESET               = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int GC_EXT_MEM_ENABLE   = 7;
  localparam int GC_UPPER_WAIT_LOW   = 6;
  localparam int CA_SECTOR_HI        = 6;
  localparam int CA_SECTOR_LO        = 4;
  localparam int CA_LOWER_WAIT_HI    = 3;
  localparam int CA_LOWER_WAIT_LO    = 2;
  localparam int CA_UPPER_WAIT_HIGH  = 1;
  localparam int CB_BUS_KEEPER       = 7;
  localparam int CB_MASK_HI          = 2;
  localparam int CB_MASK_LO          = 0;

  // writable bits of each register, others read as zero
  localparam logic [7:0] GC_WMASK = 8'hC0;
  localparam logic [7:0] CA_WMASK = 8'h7E;
  localparam logic [7:0] CB_WMASK = 8'h87;

  // ----------------------------------------------------------------
  // address space
  // ----------------------------------------------------------------
  localparam logic [15:0] EXT_SPACE_BASE = 16'h1100;
  localparam int          SECTOR_SHIFT   = 13;  // k times 0x2000
  localparam logic [2:0]  MASK_ALL       = 3'h7;

  // wait-state codes
  localparam logic [1:0] WAIT_NONE  = 2'h0;
  localparam logic [1:0] WAIT_ONE   = 2'h1;
  localparam logic [1:0] WAIT_TWO   = 2'h2;
  localparam logic [1:0] WAIT_TWOH  = 2'h3;
  localparam logic [1:0] ONE_CYCLE  = 2'h1;
  localparam logic [1:0] TWO_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    XMBC_IDLE,
    XMBC_ADDR,
    XMBC_STROBE,
    XMBC_WAIT,
    XMBC_HOLD
  } xmbc_state_e;

endpackage

// ===== rtl/xmbc_top.sv
// external memory bus configuration and strobe sequencer
// assumes cpu accesses to 0x1100 and above are routed here one at a time
// Overview of operation
// - enable bit gives address/data, high address, latch and strobes to the bus.
// - while enabled, bus pin functions override the data direction settings.
// - clearing enable returns pins to port values and direction settings.
// - legacy mode: single wait bit adds one strobe cycle.
// - nonzero limit k puts the sector split at k times 0x2000.
// - zero limit gives one sector timed by the upper wait bits.
// - lower wait field times accesses in the lower sector.
// - upper wait code joins one control-a bit and general control bit 6.
// - bus keeper holds last level on address/data lines when floating.
// - bus keeper depends on its own enable bit and on all address/data output enables being off.
// - with mask zero, all high address pins carry the high byte.
// - mask k releases top k high pins; seven releases the whole port.
`timescale 1ns/1ps
module xmbc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // i/o register port
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  // compatibility fuse
  input  wire logic        legacyMode,
  // cpu access request
  input  wire logic        accReq,
  input  wire logic        accWrite,
  input  wire logic [15:0] accAddr,
  input  wire logic [7:0]  accWrData,
  output logic             accBusy,
  output logic             accDone,
  output logic      [7:0]  accRdData,
  // port values and directions from the general-purpose ports
  input  wire logic [7:0]  portAdOut,
  input  wire logic [7:0]  portAdDir,
  input  wire logic [7:0]  portHiOut,
  input  wire logic [7:0]  portHiDir,
  input  wire logic [2:0]  portCtlOut,
  input  wire logic [2:0]  portCtlDir,
  // muxed_addr_data_lines pins
  input  wire logic [7:0]  adIn,
  output logic      [7:0]  adOut,
  output logic      [7:0]  adOe,
  // high_address_lines pins
  output logic      [7:0]  hiOut,
  output logic      [7:0]  hiOe,
  // latch and strobe pins: bit0 latch, bit1 write_n, bit2 read_n
  output logic      [2:0]  ctlOut,
  output logic      [2:0]  ctlOe,
  // bus keeper drive on the address/data lines
  output logic      [7:0]  keepOut,
  output logic             keepEn
);
  import xmbc_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]  genCtl_r, ctlA_r, ctlB_r;
  logic        extEnable, busKeeperEnable;
  logic [2:0]  sectorLimit, highMask;
  logic [1:0]  lowerWait, upperWait;

  // masked register writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      genCtl_r <= REG_RESET;
      ctlA_r   <= REG_RESET;
      ctlB_r   <= REG_RESET;
    end else if (regWrEn) begin
      unique case (regAddr)
        MCU_GENERAL_CONTROL_OFS: genCtl_r <= regWrData & GC_WMASK;
        EXT_MEM_CONTROL_A_OFS:   ctlA_r   <= regWrData & CA_WMASK;
        EXT_MEM_CONTROL_B_OFS:   ctlB_r   <= regWrData & CB_WMASK;
        default:                 ;
      endcase
    end
  end

  // registered read data, unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= REG_RESET;
    end else if (regRdEn) begin
      unique case (regAddr)
        MCU_GENERAL_CONTROL_OFS: regRdData <= genCtl_r;
        EXT_MEM_CONTROL_A_OFS:   regRdData <= ctlA_r;
        EXT_MEM_CONTROL_B_OFS:   regRdData <= ctlB_r;
        default:                 regRdData <= REG_RESET;
      endcase
    end
  end

  // field extraction
  assign extEnable       = genCtl_r[GC_EXT_MEM_ENABLE];
  assign sectorLimit     = ctlA_r[CA_SECTOR_HI:CA_SECTOR_LO];
  assign lowerWait       = ctlA_r[CA_LOWER_WAIT_HI:CA_LOWER_WAIT_LO];
  assign upperWait       = {ctlA_r[CA_UPPER_WAIT_HIGH], genCtl_r[GC_UPPER_WAIT_LOW]};
  assign busKeeperEnable = ctlB_r[CB_BUS_KEEPER];
  assign highMask        = ctlB_r[CB_MASK_HI:CB_MASK_LO];

  // ----------------------------------------------------------------
  // wait-state decode
  // ----------------------------------------------------------------
  logic [1:0]  strobeWaits;
  logic        addrHoldWait;
  logic [15:0] addr_r;
  logic        write_r;
  logic [7:0]  wdata_r;

  xmbc_wait_decode xmbc_wait_decode_inst (
    .accAddr      (addr_r),
    .sectorLimit  (sectorLimit),
    .lowerWait    (lowerWait),
    .upperWait    (upperWait),
    .legacyMode   (legacyMode),
    .strobeWaits  (strobeWaits),
    .addrHoldWait (addrHoldWait)
  );

  // ----------------------------------------------------------------
  // access sequencer: address/latch, strobe, waits, optional hold
  // ----------------------------------------------------------------
  xmbc_state_e state_r;
  logic [1:0]  waitCnt_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r   <= XMBC_IDLE;
      waitCnt_r <= 2'h0;
      addr_r    <= 16'h0000;
      write_r   <= 1'b0;
      wdata_r   <= 8'h00;
    end else begin
      unique case (state_r)
        XMBC_IDLE: if (accReq && extEnable && accAddr >= EXT_SPACE_BASE) begin
          addr_r  <= accAddr;
          write_r <= accWrite;
          wdata_r <= accWrData;
          state_r <= XMBC_ADDR;
        end
        XMBC_ADDR: begin
          waitCnt_r <= strobeWaits;
          state_r   <= XMBC_STROBE;
        end
        XMBC_STROBE: if (waitCnt_r != 2'h0) begin
          state_r <= XMBC_WAIT;
        end else begin
          state_r <= addrHoldWait ? XMBC_HOLD : XMBC_IDLE;
        end
        XMBC_WAIT: if (waitCnt_r == ONE_CYCLE) begin
          state_r   <= addrHoldWait ? XMBC_HOLD : XMBC_IDLE;
          waitCnt_r <= 2'h0;
        end else begin
          waitCnt_r <= waitCnt_r - ONE_CYCLE;
        end
        XMBC_HOLD: state_r <= XMBC_IDLE;
        default:   state_r <= XMBC_IDLE;
      endcase
    end
  end

  logic strobeOn, lastStrobe;
  assign strobeOn   = (state_r == XMBC_STROBE) || (state_r == XMBC_WAIT);
  assign lastStrobe = (state_r == XMBC_STROBE && waitCnt_r == 2'h0)
                    || (state_r == XMBC_WAIT && waitCnt_r == ONE_CYCLE);
  assign accBusy    = (state_r != XMBC_IDLE);

  // read capture at the end of the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accRdData <= 8'h00;
      accDone   <= 1'b0;
    end else begin
      accDone <= lastStrobe;
      if (lastStrobe && !write_r) begin
        accRdData <= adIn;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin multiplexing
  // ----------------------------------------------------------------
  logic [7:0] hiBusPins;

  // pins kept for the high byte: mask k releases the top k, 7 releases all
  always_comb begin
    if (highMask == MASK_ALL) begin
      hiBusPins = 8'h00;
    end else begin
      hiBusPins = 8'hFF >> highMask;
    end
  end

  // bus functions override port direction while enabled
  always_comb begin
    if (extEnable) begin
      adOe      = (state_r == XMBC_ADDR || (strobeOn && write_r)) ? 8'hFF : 8'h00;
      adOut     = (state_r == XMBC_ADDR) ? addr_r[7:0] : wdata_r;
      hiOut     = (addr_r[15:8] & hiBusPins) | (portHiOut & ~hiBusPins);
      hiOe      = hiBusPins | (portHiDir & ~hiBusPins);
      ctlOe     = 3'h7;
      ctlOut[0] = (state_r == XMBC_ADDR);
      ctlOut[1] = ~(strobeOn && write_r);
      ctlOut[2] = ~(strobeOn && !write_r);
    end else begin
      adOe   = portAdDir;
      adOut  = portAdOut;
      hiOe   = portHiDir;
      hiOut  = portHiOut;
      ctlOe  = portCtlDir;
      ctlOut = portCtlOut;
    end
  end

  // bus keeper: last seen level, gated by its own enable and by adOe being all zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      keepOut <= 8'h00;
    end else begin
      keepOut <= adIn;
    end
  end

  assign keepEn = busKeeperEnable && (adOe == 8'h00);

endmodule

// ===== rtl/xmbc_wait_decode.sv
// wait-state selection for one external access
// assumes the access address and control fields are stable while selected
`timescale 1ns/1ps
module xmbc_wait_decode (
  // access address
  input  wire logic [15:0] accAddr,
  // configuration fields
  input  wire logic [2:0]  sectorLimit,
  input  wire logic [1:0]  lowerWait,
  input  wire logic [1:0]  upperWait,
  input  wire logic        legacyMode,
  // decoded timing
  output logic      [1:0]  strobeWaits,
  output logic             addrHoldWait
);
  import xmbc_pkg::*;

  logic [1:0]  code;
  logic [15:0] boundary;

  // sector boundary and code choice, zero limit means one upper sector
  always_comb begin
    boundary = 16'(sectorLimit) << SECTOR_SHIFT;
    if (sectorLimit != 3'h0 && accAddr < boundary) begin
      code = lowerWait;
    end else begin
      code = upperWait;
    end
  end

  // code to cycle counts; legacy mode only honours the single bit
  always_comb begin
    strobeWaits  = 2'h0;
    addrHoldWait = 1'b0;
    if (legacyMode) begin
      strobeWaits = upperWait[0] ? ONE_CYCLE : 2'h0;
    end else begin
      unique case (code)
        WAIT_NONE: strobeWaits = 2'h0;
        WAIT_ONE:  strobeWaits = ONE_CYCLE;
        WAIT_TWO:  strobeWaits = TWO_CYCLES;
        WAIT_TWOH: begin
          strobeWaits  = TWO_CYCLES;
          addrHoldWait = 1'b1;
        end
      endcase
    end
  end

endmodule

// ===== tb/tb_xmbc_top.sv
// testbench for the external memory bus configuration block
// assumes the sram model on the far side of the bus pins
`timescale 1ns/1ps
module tb_xmbc_top;
  logic        clk, rst_n, regWrEn, regRdEn, legacyMode, accReq, accWrite, accBusy, accDone, keepEn;
  logic [7:0]  regAddr, regWrData, regRdData, accWrData, accRdData, portAdOut, portAdDir, portHiOut;
  logic [7:0]  portHiDir, adIn, adOut, adOe, hiOut, hiOe, keepOut, rel;
  logic [15:0] accAddr;
  logic [2:0]  portCtlOut, portCtlDir, ctlOut, ctlOe;
  int          bad_count, comparisons, n;
  logic [7:0]  ofs [3] = '{8'h35, 8'h6D, 8'h6C};
  logic [7:0]  msk [3] = '{8'hC0, 8'h7E, 8'h87};
  xmbc_top xmbc_top_inst (.*);
  xmbc_sram_model xmbc_sram_model_inst (.*);
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
    tick();
    regWrEn = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    {regAddr, regRdEn} = {a, 1'b1};
    tick();
    regRdEn = 1'b0;
    chk8(regRdData, e);
  endtask
  // one access; cycle count zero means it must be refused
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [7:0] cyc);
    {accWrite, accAddr, accWrData, accReq} = {w, a, d, 1'b1};
    tick();
    accReq = 1'b0;
    if (cyc == 8'h00) chk8({7'h00, accBusy}, 8'h00);
    else begin
      chk8({7'h00, ctlOut[0]}, 8'h01);
      chk8(adOut, a[7:0]);
      chk8(hiOe, ~rel | (portHiDir & rel));
      for (n = 1; accDone !== 1'b1 && n < 20; n++) tick();
      chk8(n[7:0], cyc);
      if (n == 20) test_done();
      if (!w) chk8(accRdData, d);
      tick();
      tick();
    end
  endtask
  function automatic logic [7:0] cyc(input int c);
    return (c == 3) ? 8'h05 : 8'h03 + c[7:0];
  endfunction
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {rst_n, regWrEn, regRdEn, legacyMode, accReq, accWrite, rel} = 14'h0000;
    {regAddr, regWrData, accWrData, accAddr} = 40'h00_0000_0000;
    {portAdOut, portAdDir, portHiOut, portHiDir} = 32'hA50F_3CF0;
    {portCtlOut, portCtlDir} = 6'h31;
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rd(ofs[i], 8'h00);
      wr(ofs[i], 8'hFF);
      rd(ofs[i], msk[i]);
      wr(ofs[i], 8'h00);
    end
    rd(8'h40, 8'h00);
    chk8(adOe, portAdDir);
    acc(1'b1, 16'h2000, 8'h11, 8'h00);
    // keeper works with the interface off and holds the last driven level
    portAdDir = 8'hFF;
    wr(8'h6C, 8'h80);
    portAdDir = 8'h00;
    tick();
    chk8({7'h00, keepEn}, 8'h01);
    chk8(keepOut, portAdOut);
    chk8(adIn, portAdOut);
    wr(8'h6C, 8'h00);
    chk8({7'h00, keepEn}, 8'h00);
    portAdDir = 8'h0F;
    wr(8'h35, 8'h80);
    acc(1'b0, 16'h10FF, 8'h00, 8'h00);
    // single sector timed by the split upper code
    for (int c = 0; c < 4; c++) begin
      wr(8'h35, {1'b1, c[0], 6'h00});
      wr(8'h6D, {6'h00, c[1], 1'b0});
      acc(1'b1, 16'hF0F0, c[7:0], cyc(c));
      acc(1'b0, 16'hF0F0, c[7:0], cyc(c));
    end
    // every sector split, last lower and first upper address
    wr(8'h35, 8'h80);
    for (int k = 1; k < 8; k++) begin
      wr(8'h6D, {1'b0, k[2:0], 4'hC});
      acc(1'b1, {k[2:0], 13'h0} - 16'h0001, 8'h5A, 8'h05);
      acc(1'b0, {k[2:0], 13'h0} - 16'h0001, 8'h5A, 8'h05);
      acc(1'b1, {k[2:0], 13'h0}, 8'hC3, 8'h03);
      acc(1'b0, {k[2:0], 13'h0}, 8'hC3, 8'h03);
    end
    // legacy mode ignores the sector fields
    legacyMode = 1'b1;
    wr(8'h6D, 8'h7E);
    for (int b = 0; b < 2; b++) begin
      wr(8'h35, {1'b1, b[0], 6'h00});
      acc(1'b1, 16'h1200, 8'h77, 8'h03 + b[7:0]);
    end
    legacyMode = 1'b0;
    wr(8'h6D, 8'h00);
    wr(8'h35, 8'h80);
    // every high-address mask value
    for (int m = 0; m < 8; m++) begin
      wr(8'h6C, m[7:0]);
      rel = (m == 7) ? 8'hFF : ~(8'hFF >> m);
      chk8(hiOut & rel, portHiOut & rel);
      acc(1'b1, 16'hABCD, 8'h3C, 8'h03);
    end
    wr(8'h35, 8'h00);
    chk8(adOut, portAdOut);
    chk8(hiOe, portHiDir);
    test_done();
  end
endmodule

// ===== tb/xmbc_sram_model.sv
// external sram with address latch on the multiplexed bus
// assumes latch pin high active and strobes low active
`timescale 1ns/1ps
module xmbc_sram_model (
  // clock
  input  wire logic       clk,
  // device pins
  input  wire logic [2:0] ctlOut,
  input  wire logic [7:0] adOut,
  input  wire logic [7:0] adOe,
  input  wire logic [7:0] hiOut,
  input  wire logic [7:0] keepOut,
  input  wire logic       keepEn,
  // resolved wire level
  output logic      [7:0] adIn
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr_r;
  logic [7:0]  last_r;
  // latch the address, store on write strobe, track wire level
  always_ff @(posedge clk) begin
    if (ctlOut[0]) addr_r <= {hiOut, adOut};
    if (!ctlOut[1]) mem[addr_r] <= adOut;
    last_r <= adIn;
  end
  // undriven wires drift unless the keeper holds them
  assign adIn = (adOe & adOut) | (~adOe & (!ctlOut[2] ? mem[addr_r] : keepEn ? keepOut : ~last_r));
endmodule

// ===== tb/xmbc_top_assertions.sv
// checker for the external memory bus configuration block
// assumes it is bound to xmbc_top, one clock, synchronous active-low reset
`timescale 1ns/1ps
module xmbc_top_assertions (
  // clock, reset and register writes
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  regAddr,
  input wire logic        regWrEn,
  input wire logic [7:0]  regWrData,
  input wire logic        legacyMode,
  // cpu access
  input wire logic        accReq,
  input wire logic [15:0] accAddr,
  input wire logic        accBusy,
  input wire logic        accDone,
  // port settings and pins
  input wire logic [7:0]  portAdOut,
  input wire logic [7:0]  portAdDir,
  input wire logic [7:0]  portHiOut,
  input wire logic [7:0]  portHiDir,
  input wire logic [7:0]  adOut,
  input wire logic [7:0]  adOe,
  input wire logic [7:0]  hiOut,
  input wire logic [7:0]  hiOe,
  input wire logic [2:0]  ctlOut,
  input wire logic [2:0]  ctlOe,
  input wire logic        keepEn
);
  logic [7:0] gc_r, ca_r, cb_r, hi_r, lo_r, cnt_r, exp_r, rel;
  logic [1:0] code;
  logic       take;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------
  // shadow registers and access bookkeeping
  // ---------------------------------------------
  // wait code of the sector that the request address hits
  always_comb begin
    take = accReq && !accBusy && gc_r[7] && accAddr >= 16'h1100;
    rel = (cb_r[2:0] == 3'h7) ? 8'hFF : ~(8'hFF >> cb_r[2:0]);
    if (legacyMode) code = {1'b0, gc_r[6]};
    else if (ca_r[6:4] != 3'h0 && accAddr < {ca_r[6:4], 13'h0}) code = ca_r[3:2];
    else code = {ca_r[1], gc_r[6]};
  end
  // copies of the control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gc_r <= 8'h00;
      ca_r <= 8'h00;
      cb_r <= 8'h00;
    end else if (regWrEn) begin
      if (regAddr == 8'h35) gc_r <= regWrData;
      if (regAddr == 8'h6D) ca_r <= regWrData;
      if (regAddr == 8'h6C) cb_r <= regWrData;
    end
  end
  // address of the taken access and cycles counted since
  always_ff @(posedge clk) begin
    if (take) begin
      hi_r <= accAddr[15:8];
      lo_r <= accAddr[7:0];
      exp_r <= (code == 2'h3) ? 8'h05 : 8'h03 + {6'h00, code};
      cnt_r <= 8'h01;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // ---------------------------------------------
  // properties
  // ---------------------------------------------
  property p_pins_off;
    !gc_r[7] && !accBusy |-> adOut == portAdOut && adOe == portAdDir && hiOut == portHiOut && hiOe == portHiDir;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins not handed back");
  property p_strobe_own;
    gc_r[7] |-> ctlOe == 3'h7;
  endproperty
  a_strobe_own: assert property (p_strobe_own) else $error("strobes not driven");
  property p_hi_addr;
    accBusy && gc_r[7] |-> (hiOe | rel) == 8'hFF && ((hiOut ^ hi_r) & ~rel) == 8'h00;
  endproperty
  a_hi_addr: assert property (p_hi_addr) else $error("high address wrong");
  property p_hi_free;
    gc_r[7] |-> ((hiOe ^ portHiDir) & rel) == 8'h00 && ((hiOut ^ portHiOut) & rel) == 8'h00;
  endproperty
  a_hi_free: assert property (p_hi_free) else $error("released pin not port");
  property p_keeper;
    1'b1 |-> keepEn == (cb_r[7] && adOe == 8'h00);
  endproperty
  a_keeper: assert property (p_keeper) else $error("keeper enable wrong");
  property p_addr_phase;
    take |=> ctlOut[0] && adOe == 8'hFF && adOut == lo_r ##1 ctlOut[2:1] != 2'h3;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address phase wrong");
  property p_length;
    accDone |-> cnt_r == exp_r;
  endproperty
  a_length: assert property (p_length) else $error("access length wrong");
  property p_bound;
    take |-> ##[3:5] accDone;
  endproperty
  a_bound: assert property (p_bound) else $error("access never done");
  property p_refuse;
    accReq && !take && !accBusy |=> !accBusy;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request not refused");
endmodule
bind xmbc_top xmbc_top_assertions xmbc_top_assertions_inst (.*);
